// file: common/vpic_pkg.sv
package vpic_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_FLAGS0 = 12'hfc0;
  localparam logic [11:0] IDX_EN0_HI = 12'hfc1;
  localparam logic [11:0] IDX_EN0_LO = 12'hfc2;
  localparam logic [11:0] IDX_FLAGS1 = 12'hfc3;
  localparam logic [11:0] IDX_EN1_HI = 12'hfc4;
  localparam logic [11:0] IDX_EN1_LO = 12'hfc5;
  localparam logic [11:0] IDX_FLAGS2 = 12'hfc6;
  localparam logic [11:0] IDX_EN2_HI = 12'hfc7;
  localparam logic [11:0] IDX_EN2_LO = 12'hfc8;
  localparam logic [11:0] IDX_EVT_STATUS = 12'hfc9;
  localparam logic [11:0] IDX_EVT_CLEAR = 12'hfca;
  localparam logic [11:0] IDX_EVT_ENABLE = 12'hfcb;
  localparam logic [11:0] IDX_EDGE_SEL = 12'hfcd;
  localparam logic [11:0] IDX_SHARE_SEL = 12'hfce;
  localparam logic [11:0] IDX_MASTER_CTL = 12'hfcf;
  // writable bits
  localparam logic [7:0] MASK_GROUP0 = 8'h79;
  localparam logic [7:0] MASK_GROUP1 = 8'hff;
  localparam logic [7:0] MASK_GROUP2 = 8'h0f;
  localparam logic [7:0] MASK_SHARE = 8'h4c;
  localparam logic [7:0] MASK_MASTER = 8'h80;
  localparam logic [2:0] MASK_EVT = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions
  localparam int BIT_TIMER1 = 6;
  localparam int BIT_TIMER0 = 5;
  localparam int BIT_SER_RX = 4;
  localparam int BIT_SER_TX = 3;
  localparam int BIT_CONVERTER = 0;
  localparam int BIT_SHARE_CMP = 6;
  localparam int BIT_SHARE_PD3 = 3;
  localparam int BIT_SHARE_PD2 = 2;
  localparam int BIT_MASTER_EN = 7;
  localparam int EVT_TRAP_TAKEN = 0;
  localparam int EVT_INTR_TAKEN = 1;
  localparam int EVT_OVERRUN = 2;
  // source codes; 0 to 16 are the maskable sources in fixed order
  localparam int NUM_MASKABLE = 17;
  localparam logic [4:0] SRC_RESET = 5'h11;
  localparam logic [4:0] SRC_WATCHDOG = 5'h12;
  localparam logic [4:0] SRC_OSC_FAIL = 5'h13;
  localparam logic [4:0] SRC_WDT_OSC_FAIL = 5'h14;
  localparam logic [4:0] SRC_ILLEGAL = 5'h15;
  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'h0002;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
  localparam logic [15:0] VEC_OSC_FAIL = 16'h003a;
  localparam logic [15:0] VEC_WDT_OSC_FAIL = 16'h003c;
  localparam logic [15:0] VEC_ILLEGAL = 16'h0006;
  localparam logic [15:0] VEC_TIMER1 = 16'h000a;
  localparam logic [15:0] VEC_TIMER0 = 16'h000c;
  localparam logic [15:0] VEC_SER_RX = 16'h000e;
  localparam logic [15:0] VEC_SER_TX = 16'h0010;
  localparam logic [15:0] VEC_CONVERTER = 16'h0016;
  localparam logic [15:0] VEC_PORTA_BASE = 16'h0018;
  localparam logic [15:0] VEC_PORTC_BASE = 16'h0030;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  typedef enum logic {VPIC_IDLE = 1'b0, VPIC_PRESENT = 1'b1} vpic_state_e;
endpackage : vpic_pkg

// file: sim/vpic_core_model.sv
`timescale 1ns/1ps
module vpic_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // vector port
  input wire logic vec_valid_q,
  input wire logic [1:0] slow,
  output logic ack_q
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ack_d;
  // take the vector after slow extra cycles, one-cycle pulse
  always_comb
  begin
    cnt_d = (vec_valid_q && !ack_q) ? cnt_q + 2'h1 : 2'h0;
    ack_d = vec_valid_q && !ack_q && cnt_q == slow;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 2'h0;
      ack_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ack_q <= ack_d;
    end
  end
endmodule : vpic_core_model

// file: sim/vpic_ctrl_properties.sv
`timescale 1ns/1ps
module vpic_ctrl_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  // vector port
  input wire logic vec_ack,
  input wire logic vec_valid_q,
  input wire logic [15:0] vec_addr_q,
  input wire logic vec_trap_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  reset_vec_first_a:
    assert property ($rose(presetn) |=> vec_valid_q && vec_trap_q && vec_addr_q == 16'h0002)
    else $error("reset vector not first");
  trap_flag_match_a:
    assert property (vec_valid_q |-> vec_trap_q ==
      (vec_addr_q inside {16'h0002, 16'h0004, 16'h003a, 16'h003c, 16'h0006}))
    else $error("trap flag wrong for vector");
  vector_legal_a:
    assert property (vec_valid_q && !vec_trap_q |-> !vec_addr_q[0] && (vec_addr_q inside
      {[16'h000a:16'h0010], 16'h0016, [16'h0018:16'h0026], [16'h0030:16'h0036]}))
    else $error("maskable vector outside table");
  vector_hold_a:
    assert property (vec_valid_q && !vec_ack |=>
      vec_valid_q && $stable(vec_addr_q) && $stable(vec_trap_q))
    else $error("presented vector changed");
  take_drops_valid_a:
    assert property (vec_valid_q && vec_ack |=> !vec_valid_q)
    else $error("vector still shown after take");
  upper_read_zero_a:
    assert property (pready_q |-> prdata_q[31:8] == 24'h0)
    else $error("read data above byte not zero");
  ready_one_cycle_a:
    assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  ready_after_wait_a:
    assert property (psel && penable && !pready_q |=> pready_q)
    else $error("ready not after one wait state");
  ready_in_access_a:
    assert property (pready_q |-> psel && penable)
    else $error("ready outside access phase");
  error_with_ready_a:
    assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
endmodule : vpic_ctrl_properties

bind vpic_ctrl vpic_ctrl_properties u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .prdata_q(prdata_q),
  .pready_q(pready_q),
  .pslverr_q(pslverr_q),
  .vec_ack(vec_ack),
  .vec_valid_q(vec_valid_q),
  .vec_addr_q(vec_addr_q),
  .vec_trap_q(vec_trap_q)
);

// file: sim/vpic_ctrl_tb.sv
`timescale 1ns/1ps
module vpic_ctrl_tb;
  import vpic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [8:0] ev = 9'h0;
  logic [7:0] porta = 8'h0;
  logic [3:2] portd = 2'h0;
  logic cmp = 1'b0;
  logic [3:0] portc = 4'h0;
  logic [1:0] slow = 2'h0;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, vec_ack, vec_valid_q, vec_trap_q, irq_q;
  logic [15:0] vec_addr_q;
  logic [31:0] rng = 32'h83f8;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_vec[$];
  int n_errors = 0;
  int n_compared = 0;
  localparam logic [11:0] WIDX [9] = '{IDX_EN0_HI, IDX_EN0_LO, IDX_EN1_HI, IDX_EN1_LO,
    IDX_EN2_HI, IDX_EN2_LO, IDX_EDGE_SEL, IDX_SHARE_SEL, IDX_MASTER_CTL};
  localparam logic [7:0] WM [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RM [9] = '{8'hff, 8'h79, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h4c, 8'h80};
  always #2.5 pclk = ~pclk;
  vpic_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .timer1_irq(ev[0]), .timer0_irq(ev[1]),
    .serial_rx_irq(ev[2]), .serial_tx_irq(ev[3]), .converter_irq(ev[4]), .porta_in(porta),
    .portd_in(portd), .comparator_out(cmp), .portc_in(portc), .watchdog_evt(ev[5]),
    .osc_fail_evt(ev[6]), .wdt_osc_fail_evt(ev[7]), .illegal_instr_evt(ev[8]),
    .vec_ack(vec_ack), .vec_valid_q(vec_valid_q), .vec_addr_q(vec_addr_q),
    .vec_trap_q(vec_trap_q), .irq_q(irq_q)
  );
  vpic_core_model u_core (
    .pclk(pclk), .presetn(presetn), .vec_valid_q(vec_valid_q), .slow(slow), .ack_q(vec_ack)
  );
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
    input logic [8:0] ex);
    exp_rd.push_back({23'h0, ex});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready_q !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 9'h0);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h0, {1'b0, e});
  endtask : rd
  task automatic pulse(input logic [8:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 9'h0;
  endtask : pulse
  task automatic vec(input logic [15:0] a, input logic t);
    exp_vec.push_back({15'h0, t, a});
  endtask : vec
  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_vec.size() != 0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    check(32'(exp_vec.size()), 32'h0);
    $display("test %s finished", name);
  endtask : drain
  // result monitor
  always @(posedge pclk)
  begin
    if (presetn && pready_q === 1'b1)
      check({23'h0, pslverr_q, pwrite ? 8'h0 : prdata_q[7:0]},
        exp_rd.size() != 0 ? exp_rd.pop_front() : 32'hdead);
    if (presetn && vec_valid_q === 1'b1 && vec_ack === 1'b1)
      check({15'h0, vec_trap_q, vec_addr_q},
        exp_vec.size() != 0 ? exp_vec.pop_front() : 32'hdead);
  end
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    vec(VEC_RESET, 1'b1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(IDX_FLAGS0 + 12'(i), 8'h00);
    rd(IDX_EDGE_SEL, 8'h00);
    apb(1'b0, 12'hfcc, 8'h0, 9'h100);
    apb(1'b1, 12'hfcc, 8'h5a, 9'h100);
    rd(IDX_EVT_CLEAR, 8'h00);
    drain("reset_and_map");
    for (int i = 0; i < 9; i++)
    begin
      rng = xorshift(rng);
      wr(WIDX[i], rng[7:0] & WM[i]);
      rd(WIDX[i], rng[7:0] & WM[i] & RM[i]);
      wr(WIDX[i], 8'h00);
    end
    pulse(9'h01f);
    rd(IDX_FLAGS0, 8'h79);
    wr(IDX_FLAGS0, 8'h00);
    rd(IDX_FLAGS0, 8'h00);
    drain("readback_and_flags");
    wr(IDX_MASTER_CTL, 8'h80);
    wr(IDX_EN0_HI, 8'h21);
    wr(IDX_EN0_LO, 8'h41);
    slow <= 2'h3;
    vec(VEC_CONVERTER, 1'b0);
    vec(VEC_TIMER0, 1'b0);
    vec(VEC_TIMER1, 1'b0);
    pulse(9'h017);
    pulse(9'h004);
    drain("levels");
    rd(IDX_FLAGS0, 8'h10);
    slow <= 2'h0;
    vec(VEC_WATCHDOG, 1'b1);
    vec(VEC_OSC_FAIL, 1'b1);
    vec(VEC_WDT_OSC_FAIL, 1'b1);
    vec(VEC_ILLEGAL, 1'b1);
    vec(VEC_TIMER1, 1'b0);
    pulse(9'h1e1);
    drain("traps");
    wr(IDX_EN1_HI, 8'hff);
    wr(IDX_EN1_LO, 8'hff);
    wr(IDX_EDGE_SEL, 8'hf0);
    for (int i = 0; i < 4; i++)
      vec(VEC_PORTA_BASE + VEC_STEP * 16'(i), 1'b0);
    porta <= 8'hff;
    drain("porta_rising");
    for (int i = 4; i < 8; i++)
      vec(VEC_PORTA_BASE + VEC_STEP * 16'(i), 1'b0);
    porta <= 8'h00;
    drain("porta_falling");
    wr(IDX_SHARE_SEL, 8'h4c);
    vec(VEC_PORTA_BASE + VEC_STEP, 1'b0);
    cmp <= 1'b1;
    drain("comparator_shared");
    portd <= 2'h3;
    repeat (3) @(posedge pclk);
    vec(16'h0020, 1'b0);
    vec(16'h0022, 1'b0);
    portd <= 2'h0;
    porta <= 8'h00;
    cmp <= 1'b0;
    drain("portd_shared");
    wr(IDX_EN2_HI, 8'h0f);
    wr(IDX_EN2_LO, 8'h0a);
    repeat (2)
    begin
      vec(16'h0030, 1'b0);
      vec(16'h0034, 1'b0);
      vec(16'h0032, 1'b0);
      vec(16'h0036, 1'b0);
      portc <= ~portc;
      drain("portc_both_edges");
    end
    rd(IDX_EVT_STATUS, 8'h07);
    wr(IDX_EVT_ENABLE, 8'h04);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_q}, 32'h1);
    wr(IDX_EVT_CLEAR, 8'h04);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_q}, 32'h0);
    rd(IDX_EVT_STATUS, 8'h03);
    wr(IDX_EVT_CLEAR, 8'h03);
    rd(IDX_EVT_STATUS, 8'h00);
    drain("event_interrupt");
    report_and_stop();
  end
endmodule : vpic_ctrl_tb

// file: src/vpic_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// - enable pair gives disabled or levels one-three
// - reset first, vector 0002H, never maskable
// - oscillator, watchdog-oscillator, illegal traps unmaskable, ordered
// - port A pins edge requests, 0018H-0026H
// - pin 6 slot shared with comparator
// - pins 3,2 slots shared with port D
// - port C pins request on both edges
// - group0 low enable layout, reserved read zero
// - group0 high enable holds companion bits
// - group2 enables bits 3-0, upper bits kept as written and read back
// - edge select picks rising or falling
// - same pair encoding for group2 bits
module vpic_ctrl #(
  parameter int ADDR_W = 14
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // peripheral request pulses
  input wire logic timer1_irq,
  input wire logic timer0_irq,
  input wire logic serial_rx_irq,
  input wire logic serial_tx_irq,
  input wire logic converter_irq,
  // pin and comparator levels
  input wire logic [7:0] porta_in,
  input wire logic [3:2] portd_in,
  input wire logic comparator_out,
  input wire logic [3:0] portc_in,
  // trap pulses
  input wire logic watchdog_evt,
  input wire logic osc_fail_evt,
  input wire logic wdt_osc_fail_evt,
  input wire logic illegal_instr_evt,
  // core vector port
  input wire logic vec_ack,
  output logic vec_valid_q,
  output logic [15:0] vec_addr_q,
  output logic vec_trap_q,
  // event interrupt
  output logic irq_q
);
  import vpic_pkg::*;

  function automatic logic [15:0] vector_of(input logic [4:0] src);
    logic [15:0] v;
    v = VEC_RESET;
    case (src)
      5'h00: v = VEC_TIMER1;
      5'h01: v = VEC_TIMER0;
      5'h02: v = VEC_SER_RX;
      5'h03: v = VEC_SER_TX;
      5'h04: v = VEC_CONVERTER;
      5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c:
        v = VEC_PORTA_BASE + VEC_STEP * {11'h000, src - 5'h05};
      5'h0d, 5'h0e, 5'h0f, 5'h10:
        v = VEC_PORTC_BASE + VEC_STEP * {11'h000, src - 5'h0d};
      SRC_WATCHDOG: v = VEC_WATCHDOG;
      SRC_OSC_FAIL: v = VEC_OSC_FAIL;
      SRC_WDT_OSC_FAIL: v = VEC_WDT_OSC_FAIL;
      SRC_ILLEGAL: v = VEC_ILLEGAL;
      default: v = VEC_RESET;
    endcase
    return v;
  endfunction : vector_of

  function automatic logic [1:0] level_of(input logic hi, input logic lo);
    return {hi, lo};
  endfunction : level_of

  // registers
  logic [7:0] flags0_q, flags0_d, flags1_q, flags1_d, flags2_q, flags2_d;
  logic [7:0] en0_hi_q, en0_hi_d, en0_lo_q, en0_lo_d;
  logic [7:0] en1_hi_q, en1_hi_d, en1_lo_q, en1_lo_d;
  logic [7:0] en2_hi_q, en2_hi_d, en2_lo_q, en2_lo_d;
  logic [7:0] edge_sel_q, edge_sel_d, share_sel_q, share_sel_d;
  logic [7:0] master_q, master_d;
  logic [2:0] evt_status_q, evt_status_d, evt_enable_q, evt_enable_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  // pin history
  logic [7:0] porta_prev_q;
  logic [3:2] portd_prev_q;
  logic cmp_prev_q;
  logic [3:0] portc_prev_q;
  // trap pending
  logic reset_pend_q, reset_pend_d, wdt_pend_q, wdt_pend_d;
  logic osc_pend_q, osc_pend_d, wosc_pend_q, wosc_pend_d, ill_pend_q, ill_pend_d;
  // presentation
  vpic_state_e state_q, state_d;
  logic [4:0] sel_q, sel_d;
  logic vec_valid_d, vec_trap_d;
  logic [15:0] vec_addr_d;

  logic [ADDR_W-3:0] word_idx;
  logic access, wr_en;
  logic [7:0] wbyte;
  logic [7:0] pa_rise, pa_fall, pa_evt, grp1_evt, grp0_evt, grp2_evt;
  logic [3:0] pc_evt;
  logic cmp_evt;
  logic [3:2] pd_evt;
  logic take;
  logic [7:0] clr0, clr1, clr2;
  logic overrun;
  logic [1:0] lvl [NUM_MASKABLE];
  logic [NUM_MASKABLE-1:0] pend;
  logic [1:0] best_lvl;
  logic [4:0] best_src;
  logic best_found;

  assign word_idx = paddr[ADDR_W-1:2];
  assign access = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign take = (state_q == VPIC_PRESENT) & vec_ack;

  // source event detection
  always_comb
  begin
    pa_rise = porta_in & ~porta_prev_q;
    pa_fall = ~porta_in & porta_prev_q;
    pa_evt = (edge_sel_q & pa_rise) | (~edge_sel_q & pa_fall);
    cmp_evt = edge_sel_q[6] ? (comparator_out & ~cmp_prev_q)
                            : (~comparator_out & cmp_prev_q);
    pd_evt = (edge_sel_q[3:2] & portd_in & ~portd_prev_q)
           | (~edge_sel_q[3:2] & ~portd_in & portd_prev_q);
    grp1_evt = pa_evt;
    if (share_sel_q[BIT_SHARE_CMP])
    begin
      grp1_evt[6] = cmp_evt;
    end
    if (share_sel_q[BIT_SHARE_PD3])
    begin
      grp1_evt[3] = pd_evt[3];
    end
    if (share_sel_q[BIT_SHARE_PD2])
    begin
      grp1_evt[2] = pd_evt[2];
    end
    pc_evt = portc_in ^ portc_prev_q;
    grp2_evt = {4'h0, pc_evt};
    grp0_evt = 8'h00;
    grp0_evt[BIT_TIMER1] = timer1_irq;
    grp0_evt[BIT_TIMER0] = timer0_irq;
    grp0_evt[BIT_SER_RX] = serial_rx_irq;
    grp0_evt[BIT_SER_TX] = serial_tx_irq;
    grp0_evt[BIT_CONVERTER] = converter_irq;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_prev_q <= 8'h00;
      portd_prev_q <= 2'h0;
      cmp_prev_q <= 1'b0;
      portc_prev_q <= 4'h0;
    end
    else
    begin
      porta_prev_q <= porta_in;
      portd_prev_q <= portd_in;
      cmp_prev_q <= comparator_out;
      portc_prev_q <= portc_in;
    end
  end

  // per-source level and pending, then arbitration
  always_comb
  begin
    lvl[0] = level_of(en0_hi_q[BIT_TIMER1], en0_lo_q[BIT_TIMER1]);
    lvl[1] = level_of(en0_hi_q[BIT_TIMER0], en0_lo_q[BIT_TIMER0]);
    lvl[2] = level_of(en0_hi_q[BIT_SER_RX], en0_lo_q[BIT_SER_RX]);
    lvl[3] = level_of(en0_hi_q[BIT_SER_TX], en0_lo_q[BIT_SER_TX]);
    lvl[4] = level_of(en0_hi_q[BIT_CONVERTER], en0_lo_q[BIT_CONVERTER]);
    pend[0] = flags0_q[BIT_TIMER1];
    pend[1] = flags0_q[BIT_TIMER0];
    pend[2] = flags0_q[BIT_SER_RX];
    pend[3] = flags0_q[BIT_SER_TX];
    pend[4] = flags0_q[BIT_CONVERTER];
    for (int i = 0; i < 8; i++)
    begin
      lvl[5 + i] = level_of(en1_hi_q[7 - i], en1_lo_q[7 - i]);
      pend[5 + i] = flags1_q[7 - i];
    end
    for (int i = 0; i < 4; i++)
    begin
      lvl[13 + i] = level_of(en2_hi_q[3 - i], en2_lo_q[3 - i]);
      pend[13 + i] = flags2_q[3 - i];
    end
    best_lvl = 2'h0;
    best_src = 5'h00;
    best_found = 1'b0;
    for (int i = 0; i < NUM_MASKABLE; i++)
    begin
      if (pend[i] && (lvl[i] > best_lvl))
      begin
        best_lvl = lvl[i];
        best_src = 5'(i);
        best_found = 1'b1;
      end
    end
  end

  // vector presentation to the core
  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    vec_valid_d = vec_valid_q;
    vec_trap_d = vec_trap_q;
    vec_addr_d = vec_addr_q;
    case (state_q)
      VPIC_IDLE:
      begin
        vec_valid_d = 1'b1;
        vec_trap_d = 1'b1;
        state_d = VPIC_PRESENT;
        if (reset_pend_q)
        begin
          sel_d = SRC_RESET;
        end
        else if (wdt_pend_q)
        begin
          sel_d = SRC_WATCHDOG;
        end
        else if (osc_pend_q)
        begin
          sel_d = SRC_OSC_FAIL;
        end
        else if (wosc_pend_q)
        begin
          sel_d = SRC_WDT_OSC_FAIL;
        end
        else if (ill_pend_q)
        begin
          sel_d = SRC_ILLEGAL;
        end
        else if (best_found && master_q[BIT_MASTER_EN])
        begin
          sel_d = best_src;
          vec_trap_d = 1'b0;
        end
        else
        begin
          vec_valid_d = 1'b0;
          vec_trap_d = 1'b0;
          state_d = VPIC_IDLE;
        end
        vec_addr_d = vector_of(sel_d);
      end
      VPIC_PRESENT:
      begin
        if (vec_ack)
        begin
          vec_valid_d = 1'b0;
          vec_trap_d = 1'b0;
          state_d = VPIC_IDLE;
        end
      end
      default:
      begin
        state_d = VPIC_IDLE;
        vec_valid_d = 1'b0;
      end
    endcase
  end

  // flags and trap pending; a new event wins over a clear
  always_comb
  begin
    clr0 = 8'h00;
    clr1 = 8'h00;
    clr2 = 8'h00;
    if (take && (sel_q < 5'(NUM_MASKABLE)))
    begin
      case (sel_q)
        5'h00: clr0[BIT_TIMER1] = 1'b1;
        5'h01: clr0[BIT_TIMER0] = 1'b1;
        5'h02: clr0[BIT_SER_RX] = 1'b1;
        5'h03: clr0[BIT_SER_TX] = 1'b1;
        5'h04: clr0[BIT_CONVERTER] = 1'b1;
        5'h0d, 5'h0e, 5'h0f, 5'h10: clr2[3'(5'h10 - sel_q)] = 1'b1;
        default: clr1[3'(5'h0c - sel_q)] = 1'b1;
      endcase
    end
    flags0_d = flags0_q & ~clr0;
    flags1_d = flags1_q & ~clr1;
    flags2_d = flags2_q & ~clr2;
    if (wr_en && (word_idx == IDX_FLAGS0))
    begin
      flags0_d = wbyte & ~clr0;
    end
    if (wr_en && (word_idx == IDX_FLAGS1))
    begin
      flags1_d = wbyte & ~clr1;
    end
    if (wr_en && (word_idx == IDX_FLAGS2))
    begin
      flags2_d = wbyte & ~clr2;
    end
    flags0_d = (flags0_d | grp0_evt) & MASK_GROUP0;
    flags1_d = (flags1_d | grp1_evt) & MASK_GROUP1;
    flags2_d = (flags2_d | grp2_evt) & MASK_GROUP2;
    overrun = |(flags0_q & grp0_evt & ~clr0) | |(flags1_q & grp1_evt & ~clr1)
            | |(flags2_q & grp2_evt & ~clr2);
    reset_pend_d = reset_pend_q & ~(take && (sel_q == SRC_RESET));
    wdt_pend_d = watchdog_evt | (wdt_pend_q & ~(take && (sel_q == SRC_WATCHDOG)));
    osc_pend_d = osc_fail_evt | (osc_pend_q & ~(take && (sel_q == SRC_OSC_FAIL)));
    wosc_pend_d = wdt_osc_fail_evt
                | (wosc_pend_q & ~(take && (sel_q == SRC_WDT_OSC_FAIL)));
    ill_pend_d = illegal_instr_evt | (ill_pend_q & ~(take && (sel_q == SRC_ILLEGAL)));
  end

  // apb register file
  always_comb
  begin
    en0_hi_d = en0_hi_q;
    en0_lo_d = en0_lo_q;
    en1_hi_d = en1_hi_q;
    en1_lo_d = en1_lo_q;
    en2_hi_d = en2_hi_q;
    en2_lo_d = en2_lo_q;
    edge_sel_d = edge_sel_q;
    share_sel_d = share_sel_q;
    master_d = master_q;
    evt_enable_d = evt_enable_q;
    evt_status_d = evt_status_q;
    if (wr_en)
    begin
      if (word_idx == IDX_EN0_HI)
      begin
        en0_hi_d = wbyte;
      end
      else if (word_idx == IDX_EN0_LO)
      begin
        en0_lo_d = wbyte & MASK_GROUP0;
      end
      else if (word_idx == IDX_EN1_HI)
      begin
        en1_hi_d = wbyte;
      end
      else if (word_idx == IDX_EN1_LO)
      begin
        en1_lo_d = wbyte;
      end
      else if (word_idx == IDX_EN2_HI)
      begin
        en2_hi_d = wbyte;
      end
      else if (word_idx == IDX_EN2_LO)
      begin
        en2_lo_d = wbyte;
      end
      else if (word_idx == IDX_EDGE_SEL)
      begin
        edge_sel_d = wbyte;
      end
      else if (word_idx == IDX_SHARE_SEL)
      begin
        share_sel_d = wbyte & MASK_SHARE;
      end
      else if (word_idx == IDX_MASTER_CTL)
      begin
        master_d = wbyte & MASK_MASTER;
      end
      else if (word_idx == IDX_EVT_ENABLE)
      begin
        evt_enable_d = wbyte[2:0] & MASK_EVT;
      end
      else if (word_idx == IDX_EVT_CLEAR)
      begin
        evt_status_d = evt_status_q & ~wbyte[2:0];
      end
    end
    evt_status_d[EVT_TRAP_TAKEN] = evt_status_d[EVT_TRAP_TAKEN] | (take & vec_trap_q);
    evt_status_d[EVT_INTR_TAKEN] = evt_status_d[EVT_INTR_TAKEN] | (take & ~vec_trap_q);
    evt_status_d[EVT_OVERRUN] = evt_status_d[EVT_OVERRUN] | overrun;
    irq_d = |(evt_status_d & evt_enable_d);
    pready_d = access;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (access && !pwrite)
    begin
      if (word_idx == IDX_FLAGS0)
      begin
        prdata_d[7:0] = flags0_q;
      end
      else if (word_idx == IDX_EN0_HI)
      begin
        prdata_d[7:0] = en0_hi_q;
      end
      else if (word_idx == IDX_EN0_LO)
      begin
        prdata_d[7:0] = en0_lo_q & MASK_GROUP0;
      end
      else if (word_idx == IDX_FLAGS1)
      begin
        prdata_d[7:0] = flags1_q;
      end
      else if (word_idx == IDX_EN1_HI)
      begin
        prdata_d[7:0] = en1_hi_q;
      end
      else if (word_idx == IDX_EN1_LO)
      begin
        prdata_d[7:0] = en1_lo_q;
      end
      else if (word_idx == IDX_FLAGS2)
      begin
        prdata_d[7:0] = flags2_q;
      end
      else if (word_idx == IDX_EN2_HI)
      begin
        prdata_d[7:0] = en2_hi_q;
      end
      else if (word_idx == IDX_EN2_LO)
      begin
        prdata_d[7:0] = en2_lo_q;
      end
      else if (word_idx == IDX_EDGE_SEL)
      begin
        prdata_d[7:0] = edge_sel_q;
      end
      else if (word_idx == IDX_SHARE_SEL)
      begin
        prdata_d[7:0] = share_sel_q;
      end
      else if (word_idx == IDX_MASTER_CTL)
      begin
        prdata_d[7:0] = master_q;
      end
      else if (word_idx == IDX_EVT_STATUS)
      begin
        prdata_d[2:0] = evt_status_q;
      end
      else if (word_idx == IDX_EVT_ENABLE)
      begin
        prdata_d[2:0] = evt_enable_q;
      end
      else if (word_idx != IDX_EVT_CLEAR)
      begin
        pslverr_d = 1'b1;
      end
    end
    else if (access && pwrite)
    begin
      if ((word_idx < IDX_FLAGS0) || (word_idx > IDX_MASTER_CTL) || (word_idx == 12'hfcc))
      begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags0_q <= RESET_BYTE;
      flags1_q <= RESET_BYTE;
      flags2_q <= RESET_BYTE;
      en0_hi_q <= RESET_BYTE;
      en0_lo_q <= RESET_BYTE;
      en1_hi_q <= RESET_BYTE;
      en1_lo_q <= RESET_BYTE;
      en2_hi_q <= RESET_BYTE;
      en2_lo_q <= RESET_BYTE;
      edge_sel_q <= RESET_BYTE;
      share_sel_q <= RESET_BYTE;
      master_q <= RESET_BYTE;
      evt_status_q <= 3'h0;
      evt_enable_q <= 3'h0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      reset_pend_q <= 1'b1;
      wdt_pend_q <= 1'b0;
      osc_pend_q <= 1'b0;
      wosc_pend_q <= 1'b0;
      ill_pend_q <= 1'b0;
      state_q <= VPIC_IDLE;
      sel_q <= 5'h00;
      vec_valid_q <= 1'b0;
      vec_trap_q <= 1'b0;
      vec_addr_q <= 16'h0000;
    end
    else
    begin
      flags0_q <= flags0_d;
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
      en0_hi_q <= en0_hi_d;
      en0_lo_q <= en0_lo_d;
      en1_hi_q <= en1_hi_d;
      en1_lo_q <= en1_lo_d;
      en2_hi_q <= en2_hi_d;
      en2_lo_q <= en2_lo_d;
      edge_sel_q <= edge_sel_d;
      share_sel_q <= share_sel_d;
      master_q <= master_d;
      evt_status_q <= evt_status_d;
      evt_enable_q <= evt_enable_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      reset_pend_q <= reset_pend_d;
      wdt_pend_q <= wdt_pend_d;
      osc_pend_q <= osc_pend_d;
      wosc_pend_q <= wosc_pend_d;
      ill_pend_q <= ill_pend_d;
      state_q <= state_d;
      sel_q <= sel_d;
      vec_valid_q <= vec_valid_d;
      vec_trap_q <= vec_trap_d;
      vec_addr_q <= vec_addr_d;
    end
  end
endmodule : vpic_ctrl
